// [src/fault_pin_mask_block.sv]
// fault_pin_mask_block: mask register choosing which diagnostics drive the
// field fault pin, plus a dummy address that accepts writes and stores nothing
// assumes: fault sources, latched status and status-read pulse come from
// logic on mclk; the serial port pins come from outside and are synchronised
`timescale 1ns/100ps

module fault_pin_mask_block
  import fault_pin_pkg::*;
(
  input  wire logic       mclk,                     // block clock, 10 MHz
  input  wire logic       reset,                    // synchronous reset, active high
  input  wire logic       spi_cs_n,                 // chip select pin, active low
  input  wire logic       spi_sclk,                 // serial clock pin
  input  wire logic       spi_mosi,                 // serial data in pin
  output logic            spi_miso,                 // serial data out pin
  input  wire logic [7:0] input_states,             // filtered input levels
  input  wire logic [7:0] wire_break_bits,          // per-channel wire-break flags
  input  wire logic [7:0] fault_sources_rt,         // real-time source conditions
  input  wire logic [7:0] first_fault_status,       // latched status bits
  input  wire logic       first_fault_status_read,  // pulse: host read status
  input  wire logic       fault_pin_sticky,         // sticky pin mode select
  output logic            field_fault_pin_n,        // fault pin, active low
  output logic [7:0]      fault_pin_source_mask     // current mask value
);

  logic [7:0]  mask_r;
  logic        hold_r;
  logic        hold_nxt;
  logic        pin_n_r;
  logic        pin_n_nxt;
  logic [7:0]  gated_rt;
  logic [7:0]  head_byte;
  logic        head_done;
  logic        frame_done;
  logic [15:0] frame_word;
  logic [7:0]  tx_second;
  logic        head_write;
  logic [6:0]  head_addr;
  logic        wr_mask;
  logic        wr_dummy;

  function automatic logic any_unmasked(input logic [7:0] src, input logic [7:0] msk);
    any_unmasked = |(src & msk);
  endfunction

  function automatic logic src_on(input logic [7:0] src, input logic [7:0] msk, input int b);
    src_on = src[b] & msk[b];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // serial port
  spi_frame_engine #(
    .BITS       (FRAME_BITS)
  ) u_frame (
    .mclk       (mclk),
    .reset      (reset),
    .spi_cs_n   (spi_cs_n),
    .spi_sclk   (spi_sclk),
    .spi_mosi   (spi_mosi),
    .spi_miso   (spi_miso),
    .tx_first   (input_states),
    .tx_second  (tx_second),
    .head_byte  (head_byte),
    .head_done  (head_done),
    .frame_done (frame_done),
    .frame_word (frame_word)
  );

  assign head_write = head_byte[7];
  assign head_addr  = head_byte[6:0];

  // second byte: mask data on mask reads, READ_FILL on other reads, wire-break bits on every write
  always_comb begin
    if (head_write) begin
      tx_second = wire_break_bits;
    end else if (head_addr == MASK_ADDR) begin
      tx_second = mask_r;
    end else begin
      tx_second = READ_FILL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  assign wr_mask  = frame_done && frame_word[WRITE_FLAG_BIT]
                    && frame_word[14:8] == MASK_ADDR;
  assign wr_dummy = frame_done && frame_word[WRITE_FLAG_BIT]
                    && frame_word[14:8] == DUMMY_ADDR;

  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_r <= MASK_RESET;
    end else if (wr_mask) begin
      mask_r <= frame_word[7:0];
    end
  end
  // dummy address decodes to nothing, so wr_dummy stores no data

  assign fault_pin_source_mask = mask_r;

  ////////////////////////////////////////////////////////////////////////////////
  // fault pin
  always_comb begin
    if (!fault_pin_sticky) begin
      hold_nxt = 1'b0;
    end else if (any_unmasked(first_fault_status, mask_r)) begin
      hold_nxt = 1'b1;
    end else if (first_fault_status_read) begin
      hold_nxt = 1'b0;
    end else begin
      hold_nxt = hold_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // each mask bit gates its own real-time source onto the pin when fault_pin_sticky is low
  always_comb begin
    gated_rt                  = 8'h00;
    gated_rt[CRC_ERR_BIT]     = src_on(fault_sources_rt, mask_r, CRC_ERR_BIT);
    gated_rt[POWER_ON_BIT]    = src_on(fault_sources_rt, mask_r, POWER_ON_BIT);
    gated_rt[SECONDARY_BIT]   = src_on(fault_sources_rt, mask_r, SECONDARY_BIT);
    gated_rt[UPPER_TEMP_BIT]  = src_on(fault_sources_rt, mask_r, UPPER_TEMP_BIT);
    gated_rt[LOWER_TEMP_BIT]  = src_on(fault_sources_rt, mask_r, LOWER_TEMP_BIT);
    gated_rt[SUPPLY_LOW_BIT]  = src_on(fault_sources_rt, mask_r, SUPPLY_LOW_BIT);
    gated_rt[SUPPLY_MISS_BIT] = src_on(fault_sources_rt, mask_r, SUPPLY_MISS_BIT);
    gated_rt[WIRE_BREAK_BIT]  = src_on(fault_sources_rt, mask_r, WIRE_BREAK_BIT);
  end

  always_comb begin
    if (fault_pin_sticky) begin
      pin_n_nxt = ~hold_nxt;
    end else begin
      pin_n_nxt = ~|gated_rt;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_n_r <= 1'b1;
    end else begin
      pin_n_r <= pin_n_nxt;
    end
  end

  assign field_fault_pin_n = pin_n_r;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_gate_bit(int b);
    @(posedge mclk) disable iff (reset)
      (!fault_pin_sticky && fault_sources_rt == (8'h01 << b))
      |=> (field_fault_pin_n == !$past(mask_r[b]));
  endproperty

  a_gate_crc:          assert property (p_gate_bit(CRC_ERR_BIT))
    else $error("crc error gating wrong");
  a_gate_power_on:     assert property (p_gate_bit(POWER_ON_BIT))
    else $error("power-on gating wrong");
  a_gate_secondary:    assert property (p_gate_bit(SECONDARY_BIT))
    else $error("secondary summary gating wrong");
  a_gate_upper_temp:   assert property (p_gate_bit(UPPER_TEMP_BIT))
    else $error("upper temperature gating wrong");
  a_gate_lower_temp:   assert property (p_gate_bit(LOWER_TEMP_BIT))
    else $error("lower temperature gating wrong");
  a_gate_supply_low:   assert property (p_gate_bit(SUPPLY_LOW_BIT))
    else $error("supply low gating wrong");
  a_gate_supply_miss:  assert property (p_gate_bit(SUPPLY_MISS_BIT))
    else $error("supply missing gating wrong");
  a_gate_wire_break:   assert property (p_gate_bit(WIRE_BREAK_BIT))
    else $error("wire break gating wrong");

  property p_mask_reset;
    @(posedge mclk)
      $fell(reset) |-> (mask_r == MASK_RESET) && field_fault_pin_n;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not at reset value after reset");

  property p_dummy_no_store;
    @(posedge mclk) disable iff (reset)
      wr_dummy |=> $stable(mask_r);
  endproperty
  a_dummy_no_store: assert property (p_dummy_no_store)
    else $error("dummy write changed the mask");

  property p_write_second_byte;
    @(posedge mclk) disable iff (reset)
      head_done && head_write |=> u_frame.tx_r[14:7] == $past(wire_break_bits);
  endproperty
  a_write_second_byte: assert property (p_write_second_byte)
    else $error("write frame does not return wire-break bits");

  property p_nonsticky_or;
    @(posedge mclk) disable iff (reset)
      !fault_pin_sticky ##1 !fault_pin_sticky
      |-> field_fault_pin_n == !$past(|(fault_sources_rt & mask_r));
  endproperty
  a_nonsticky_or: assert property (p_nonsticky_or)
    else $error("pin does not follow unmasked real-time sources");

  property p_sticky_holds;
    @(posedge mclk) disable iff (reset)
      fault_pin_sticky && |(first_fault_status & mask_r)
      ##1 (fault_pin_sticky && !first_fault_status_read)[*2]
      |-> !field_fault_pin_n;
  endproperty
  a_sticky_holds: assert property (p_sticky_holds)
    else $error("sticky pin released without a status read");

  property p_sticky_release;
    @(posedge mclk) disable iff (reset)
      fault_pin_sticky && first_fault_status_read
      && !(|(first_fault_status & mask_r))
      |=> field_fault_pin_n;
  endproperty
  a_sticky_release: assert property (p_sticky_release)
    else $error("sticky pin not released after status read");

  property p_mask_write;
    @(posedge mclk) disable iff (reset)
      wr_mask |=> mask_r == $past(frame_word[7:0]) ##1 1'b1;
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask did not take written value");

  property p_mask_readback;
    @(posedge mclk) disable iff (reset)
      head_done && !head_write && head_addr == MASK_ADDR
      |=> u_frame.tx_r[14:7] == $past(mask_r);
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("mask read returns wrong data");

  property p_mask_hold;
    @(posedge mclk) disable iff (reset)
      !wr_mask |=> $stable(mask_r);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without a mask write");

  property p_full_frame;
    @(posedge mclk) disable iff (reset)
      wr_mask |-> u_frame.cnt_r == FRAME_BITS;
  endproperty
  a_full_frame: assert property (p_full_frame)
    else $error("mask written by a frame of wrong length");

  property p_first_byte;
    @(posedge mclk) disable iff (reset)
      u_frame.start |=> u_frame.tx_r[15:8] == $past(input_states);
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("frame does not start with the input states");

  property p_dummy_read_fill;
    @(posedge mclk) disable iff (reset)
      head_done && !head_write && head_addr == DUMMY_ADDR
      |=> u_frame.tx_r[14:7] == READ_FILL;
  endproperty
  a_dummy_read_fill: assert property (p_dummy_read_fill)
    else $error("dummy read returns stored data");

  property p_sticky_set;
    @(posedge mclk) disable iff (reset)
      fault_pin_sticky && |(first_fault_status & mask_r) |=> !field_fault_pin_n;
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("sticky pin not asserted by unmasked status");

  property p_sticky_quiet;
    @(posedge mclk) disable iff (reset)
      fault_pin_sticky && !hold_r && !(|(first_fault_status & mask_r))
      |=> field_fault_pin_n;
  endproperty
  a_sticky_quiet: assert property (p_sticky_quiet)
    else $error("sticky pin asserted without unmasked status");

  c_mask_write:   cover property (@(posedge mclk) disable iff (reset) wr_mask);
  c_dummy_write:  cover property (@(posedge mclk) disable iff (reset) wr_dummy);
  c_mask_read:    cover property (@(posedge mclk) disable iff (reset)
                    head_done && !head_write && head_addr == MASK_ADDR);
  c_sticky_clear: cover property (@(posedge mclk) disable iff (reset)
                    hold_r ##1 !hold_r);
  c_set_beats_read: cover property (@(posedge mclk) disable iff (reset)
                    fault_pin_sticky && first_fault_status_read && |(first_fault_status & mask_r));

endmodule // fault_pin_mask_block

// [src/fault_pin_pkg.sv]
// package: register map, field layout and frame format of the fault-pin mask block
// assumes: serial frames of two bytes, head byte first, msb first
package fault_pin_pkg;

  // register addresses on the serial port
  localparam logic [6:0] MASK_ADDR       = 7'h24;
  localparam logic [6:0] DUMMY_ADDR      = 7'h26;

  // reset value of the mask register
  localparam logic [7:0] MASK_RESET      = 8'hc0;

  // mask and source bit positions
  localparam int         CRC_ERR_BIT     = 7;
  localparam int         POWER_ON_BIT    = 6;
  localparam int         SECONDARY_BIT   = 5;
  localparam int         UPPER_TEMP_BIT  = 4;
  localparam int         LOWER_TEMP_BIT  = 3;
  localparam int         SUPPLY_LOW_BIT  = 2;
  localparam int         SUPPLY_MISS_BIT = 1;
  localparam int         WIRE_BREAK_BIT  = 0;

  // frame layout: head byte {write, addr[6:0]}, then one data byte
  localparam int         FRAME_BITS      = 16;
  localparam int         HEAD_BITS       = 8;
  localparam int         WRITE_FLAG_BIT  = 15;
  localparam logic [7:0] READ_FILL       = 8'h00;

  // one-hot states of the serial frame engine
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } frame_state_e;

endpackage

// [src/spi_frame_engine.sv]
// spi_frame_engine: serial slave shifter, mode 0, msb first, two-byte frames
// assumes: chip select, clock and data arrive from pins, sclk far slower than mclk
`timescale 1ns/100ps

module spi_frame_engine
  import fault_pin_pkg::*;
#(
  parameter int BITS = FRAME_BITS          // bits per frame
) (
  input  wire logic              mclk,        // block clock
  input  wire logic              reset,       // synchronous reset, active high
  input  wire logic              spi_cs_n,    // chip select pin, active low
  input  wire logic              spi_sclk,    // serial clock pin
  input  wire logic              spi_mosi,    // serial data in pin
  output logic                   spi_miso,    // serial data out pin
  input  wire logic [7:0]        tx_first,    // byte sent during head byte
  input  wire logic [7:0]        tx_second,   // byte sent during data byte
  output logic [7:0]             head_byte,   // head byte as it completes
  output logic                   head_done,   // pulse at last head bit sample
  output logic                   frame_done,  // pulse after a complete frame
  output logic [BITS-1:0]        frame_word   // received frame
);

  localparam int CW = $clog2(BITS + 1);

  logic cs_meta_r, cs_sync_r, cs_prev_r;
  logic ck_meta_r, ck_sync_r, ck_prev_r;
  logic di_meta_r, di_sync_r;
  frame_state_e state_r;
  logic [CW-1:0]   cnt_r;
  logic [BITS-1:0] rx_r;
  logic [BITS-1:0] tx_r;
  logic            done_r;
  logic [BITS-1:0] word_r;
  logic            start, stop, rise, fall;

  ////////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; the first stage is not read, the second stage and the prev flops on cs and sclk are
  always_ff @(posedge mclk) begin
    if (reset) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      ck_meta_r <= 1'b0;
      ck_sync_r <= 1'b0;
      ck_prev_r <= 1'b0;
      di_meta_r <= 1'b0;
      di_sync_r <= 1'b0;
    end else begin
      cs_meta_r <= spi_cs_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      ck_meta_r <= spi_sclk;
      ck_sync_r <= ck_meta_r;
      ck_prev_r <= ck_sync_r;
      di_meta_r <= spi_mosi;
      di_sync_r <= di_meta_r;
    end
  end

  assign start = cs_prev_r & ~cs_sync_r;
  assign stop  = ~cs_prev_r & cs_sync_r;
  assign rise  = ~cs_sync_r & ck_sync_r & ~ck_prev_r;
  assign fall  = ~cs_sync_r & ~ck_sync_r & ck_prev_r;

  ////////////////////////////////////////////////////////////////////////////////
  // frame state and bit count
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (start) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (stop) begin
            state_r <= ST_IDLE;
          end else if (rise && cnt_r != CW'(BITS)) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive on rising edge, transmit changes on falling edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_r <= '0;
      tx_r <= '0;
    end else if (start) begin
      rx_r <= '0;
      tx_r <= {tx_first, {(BITS-8){1'b0}}};
    end else if (state_r == ST_SHIFT && rise) begin
      rx_r <= {rx_r[BITS-2:0], di_sync_r};
      if (cnt_r == CW'(HEAD_BITS - 1)) begin
        tx_r <= {tx_r[BITS-1], tx_second, {(BITS-9){1'b0}}};
      end
    end else if (state_r == ST_SHIFT && fall) begin
      tx_r <= {tx_r[BITS-2:0], 1'b0};
    end else if (state_r == ST_IDLE) begin
      tx_r <= '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      done_r <= 1'b0;
      word_r <= '0;
    end else begin
      done_r <= stop && state_r == ST_SHIFT && cnt_r == CW'(BITS);
      if (stop) begin
        word_r <= rx_r;
      end
    end
  end

  assign head_byte  = {rx_r[6:0], di_sync_r};
  assign head_done  = state_r == ST_SHIFT && rise && cnt_r == CW'(HEAD_BITS - 1);
  assign spi_miso   = tx_r[BITS-1];
  assign frame_done = done_r;
  assign frame_word = word_r;

endmodule // spi_frame_engine

// [dv/spi_host_model.sv]
// spi_host_model: host controller side of the serial port, mode 0, msb first
// assumes: tb calls xfer; pins change only at the falling mclk edge
`timescale 1ns/100ps

module spi_host_model (
  input  wire logic mclk,      // block clock
  output logic      spi_cs_n,  // chip select, active low
  output logic      spi_sclk,  // serial clock, idle low
  output logic      spi_mosi,  // serial data to block
  input  wire logic spi_miso   // serial data from block
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  task automatic wait_neg(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // half: mclk cycles per sclk phase, at least 4; nbits short of 16 sends a short frame of nbits clocks
  task automatic xfer(input logic [15:0] tx, input int nbits, input int half,
                      output logic [15:0] rx);
    rx = 16'h0000;
    wait_neg(1);
    spi_cs_n = 1'b0;
    spi_mosi = tx[15];  // any head byte, dummy address included
    wait_neg(half);
    for (int i = 0; i < nbits; i++) begin
      spi_sclk = 1'b1;
      rx = {rx[14:0], spi_miso};
      wait_neg(half);
      spi_sclk = 1'b0;
      spi_mosi = (i < 15) ? tx[14-i] : ~spi_mosi;
      wait_neg(half);
    end
    spi_cs_n = 1'b1;
    // released line is inverted; after a full frame it shows the last data bit again
    spi_mosi = ~spi_mosi;
    wait_neg(10);
  endtask
endmodule // spi_host_model

// [dv/tb_top.sv]
// tb_top: register and fault pin tests of fault_pin_mask_block over its serial port
// assumes: spi_host_model drives the port; inputs change at the falling mclk edge
`timescale 1ns/100ps

module tb_top
  import fault_pin_pkg::*;
();
  localparam int CYCLE_LIMIT = 20000;
  logic        mclk;
  logic        reset;
  logic        spi_cs_n;
  logic        spi_sclk;
  logic        spi_mosi;
  logic        spi_miso;
  logic [7:0]  input_states;
  logic [7:0]  wire_break_bits;
  logic [7:0]  fault_sources_rt;
  logic [7:0]  first_fault_status;
  logic        first_fault_status_read;
  logic        fault_pin_sticky;
  logic        field_fault_pin_n;
  logic [7:0]  fault_pin_source_mask;
  logic [15:0] rx;
  int          n_mismatch;
  int          cmp_count;
  int          cycles;

  fault_pin_mask_block i_fault_pin_mask_block (
    .mclk(mclk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .input_states(input_states),
    .wire_break_bits(wire_break_bits), .fault_sources_rt(fault_sources_rt),
    .first_fault_status(first_fault_status),
    .first_fault_status_read(first_fault_status_read),
    .fault_pin_sticky(fault_pin_sticky), .field_fault_pin_n(field_fault_pin_n),
    .fault_pin_source_mask(fault_pin_source_mask)
  );

  spi_host_model i_spi_host_model (
    .mclk(mclk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_spi_host_model.xfer({1'b1, a, d}, FRAME_BITS, 4, rx);
  endtask

  task automatic rd(input logic [6:0] a);
    i_spi_host_model.xfer({1'b0, a, 8'h00}, FRAME_BITS, 7, rx);
  endtask

  task automatic pin_is(input logic exp, input string what);
    ticks(2);
    check({15'h0000, field_fault_pin_n}, {15'h0000, exp}, what);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      n_mismatch++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    reset = 1'b1;
    input_states = 8'ha5;
    wire_break_bits = 8'h3c;
    fault_sources_rt = 8'h00;
    first_fault_status = 8'h00;
    first_fault_status_read = 1'b0;
    fault_pin_sticky = 1'b0;
    ticks(20);
    check({8'h00, fault_pin_source_mask}, {8'h00, MASK_RESET}, "mask at reset");
    check({14'h0000, field_fault_pin_n, spi_miso}, 16'h0002, "pins at reset");
    reset = 1'b0;
    ticks(2);
    rd(MASK_ADDR);
    check(rx, {input_states, MASK_RESET}, "read mask after reset");
    fault_sources_rt = 8'h3f;
    pin_is(1'b1, "reset mask blocks low sources");
    fault_sources_rt = 8'h40;
    pin_is(1'b0, "reset mask passes power-on");
    // one enable at a time: its source alone asserts, all others stay masked
    for (int b = 0; b < 8; b++) begin
      input_states = {input_states[6:0], input_states[7]};
      wr(MASK_ADDR, 8'h01 << b);
      check({8'h00, fault_pin_source_mask}, {8'h00, 8'h01 << b}, "mask written");
      fault_sources_rt = ~(8'h01 << b);
      pin_is(1'b1, "other sources masked");
      fault_sources_rt = 8'h01 << b;
      pin_is(1'b0, "enabled source asserts");
    end
    wr(MASK_ADDR, 8'h3c);
    wire_break_bits = 8'hc3;
    wr(DUMMY_ADDR, 8'hff);
    check(rx, {input_states, wire_break_bits}, "dummy write shifts data");
    check({8'h00, fault_pin_source_mask}, 16'h003c, "dummy write stores nothing");
    rd(DUMMY_ADDR);
    check(rx, {input_states, READ_FILL}, "dummy read fill");
    i_spi_host_model.xfer({1'b1, MASK_ADDR, 8'h81}, FRAME_BITS - 1, 4, rx);
    rd(MASK_ADDR);
    check(rx, {input_states, 8'h3c}, "short frame ignored");
    // sticky mode follows latched status until the host reads it
    wr(MASK_ADDR, 8'h81);
    fault_sources_rt = 8'h00;
    fault_pin_sticky = 1'b1;
    first_fault_status = 8'h7e;
    pin_is(1'b1, "masked status ignored");
    first_fault_status = 8'h01;
    pin_is(1'b0, "unmasked status asserts");
    first_fault_status = 8'h00;
    ticks(5);
    pin_is(1'b0, "pin held until read");
    first_fault_status_read = 1'b1;
    ticks(1);
    first_fault_status_read = 1'b0;
    pin_is(1'b1, "read releases pin");
    first_fault_status = 8'h80;
    first_fault_status_read = 1'b1;
    ticks(1);
    first_fault_status_read = 1'b0;
    first_fault_status = 8'h00;
    pin_is(1'b0, "new status beats read");
    fault_pin_sticky = 1'b0;
    pin_is(1'b1, "non-sticky follows sources");
    fault_sources_rt = 8'h80;
    pin_is(1'b0, "crc source asserts");
    // second reset in mid-run restores the default mask
    fault_sources_rt = 8'h00;
    reset = 1'b1;
    ticks(2);
    reset = 1'b0;
    ticks(2);
    rd(MASK_ADDR);
    check(rx, {input_states, MASK_RESET}, "mask after second reset");
    stop_test();
  end
endmodule // tb_top
